// >>> dv/ogc_ctrl_props.sv
// assertion checker for the retry and pulse-gate control block
`timescale 1ns/10ps
module ogc_ctrl_props #(
	parameter int OFF_DELAY_CYC = 4,
	parameter int RATE_LO_CYC   = 20,
	parameter int RATE_HI_CYC   = 12
) (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        reg_wr_en,
	input wire logic [1:0]  reg_wr_idx,
	input wire logic [15:0] reg_wr_data,
	input wire logic [15:0] ctrl2_rd_data,
	input wire logic [15:0] ctrl3_rd_data,
	input wire logic        global_enable,
	input wire logic [5:0]  upper_on_req,
	input wire logic [5:0]  lower_on_req,
	input wire logic [4:0]  single_on_req,
	input wire logic        pulse_gate_input_a,
	input wire logic        pulse_gate_input_b,
	input wire logic [16:0] overcurrent_det,
	input wire logic [1:0]  status_clr,
	input wire logic [15:0] overcurrent_flag_word0,
	input wire logic [15:0] overcurrent_flag_word1,
	input wire logic [5:0]  upper_switch_on,
	input wire logic [5:0]  lower_switch_on,
	input wire logic [4:0]  single_switch_on
);
	// slow rate bound covers the fast one too
	localparam int RMAX = OFF_DELAY_CYC + RATE_LO_CYC + 6;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////
	chk_w2_store: assert property (reg_wr_en && global_enable && reg_wr_idx == 2'h2 |=>
		ctrl2_rd_data == ($past(reg_wr_data) & 16'hFCFC)) else $error("word 2 readback");
	chk_w3_store: assert property (reg_wr_en && global_enable && reg_wr_idx == 2'h3 |=>
		ctrl3_rd_data == ($past(reg_wr_data) & 16'hFFE0)) else $error("word 3 readback");
	chk_standby_clear: assert property (!global_enable |=>
		ctrl2_rd_data == 16'h0000 && ctrl3_rd_data == 16'h0000) else $error("standby");
	chk_no_cross: assert property ((upper_switch_on & lower_switch_on) == 6'h00)
		else $error("both bridge switches on");
	chk_trip_word0: assert property (global_enable && overcurrent_det[0]
		&& upper_switch_on[0] |=> overcurrent_flag_word0[15] && !upper_switch_on[0])
		else $error("trip word 0");
	chk_trip_word1: assert property (global_enable && overcurrent_det[12]
		&& single_switch_on[0] |=> overcurrent_flag_word1[15] && !single_switch_on[0])
		else $error("trip word 1");
	chk_off_hold: assert property (global_enable && overcurrent_det[12]
		&& single_switch_on[0] |=> !single_switch_on[0] [*4]) else $error("off delay short");
	chk_retry_soon: assert property (global_enable && overcurrent_det[12]
		&& single_switch_on[0] |-> ##[1:RMAX] (single_switch_on[0] || !single_on_req[0]
		|| !global_enable || !ctrl3_rd_data[15] || ctrl3_rd_data[10])) else $error("no retry");
	chk_gate_a_low: assert property ((ctrl2_rd_data[7] && !pulse_gate_input_a) [*3] |=>
		!upper_switch_on[0] && !lower_switch_on[0]) else $error("gate a");
	chk_gate_b_low: assert property ((ctrl2_rd_data[3] && !pulse_gate_input_b) [*3] |=>
		!upper_switch_on[4] && !lower_switch_on[4]) else $error("gate b");
endmodule

// >>> dv/ogc_host_model.sv
// microcontroller model: control word writes and pulse inputs
`timescale 1ns/10ps
module ogc_host_model (
	// clock
	input  wire logic   core_clk,
	// write port
	output logic        reg_wr_en,
	output logic [1:0]  reg_wr_idx,
	output logic [15:0] reg_wr_data,
	// pulse inputs
	output logic        pulse_gate_input_a,
	output logic        pulse_gate_input_b
);
	initial begin
		reg_wr_en = 1'b0;
		reg_wr_idx = 2'h0;
		reg_wr_data = 16'h0000;
		pulse_gate_input_a = 1'b0;
		pulse_gate_input_b = 1'b0;
	end
	// call at a falling edge; raw breaks the zero fill on purpose
	task automatic wr(input logic [1:0] idx, input logic [15:0] d, input logic raw);
		reg_wr_en = 1'b1;
		reg_wr_idx = idx;
		reg_wr_data = (idx == 2'h2 && !raw) ? (d & 16'hFCFF) : d;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
		// no stale data once released
		reg_wr_data = ~reg_wr_data;
		@(negedge core_clk);
	endtask
	task automatic pulse(input logic a, input logic b);
		pulse_gate_input_a = a;
		pulse_gate_input_b = b;
	endtask
endmodule

// >>> dv/tb_ogc_ctrl.sv
// self-checking bench for the retry and pulse-gate control block
`timescale 1ns/10ps
module tb_ogc_ctrl;
	localparam int OFF = 4;
	localparam int PLO = 20;
	localparam int PHI = 12;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        global_enable = 1'b0;
	logic [5:0]  upper_on_req = 6'h00;
	logic [5:0]  lower_on_req = 6'h00;
	logic [4:0]  single_on_req = 5'h00;
	logic [16:0] overcurrent_det = 17'h00000;
	logic [1:0]  status_clr = 2'h0;
	logic        reg_wr_en;
	logic [1:0]  reg_wr_idx;
	logic [15:0] reg_wr_data;
	logic        pulse_gate_input_a;
	logic        pulse_gate_input_b;
	logic [15:0] ctrl2_rd_data;
	logic [15:0] ctrl3_rd_data;
	logic [15:0] overcurrent_flag_word0;
	logic [15:0] overcurrent_flag_word1;
	logic [5:0]  upper_switch_on;
	logic [5:0]  lower_switch_on;
	logic [4:0]  single_switch_on;
	int          err_count = 0;
	int          tests_run = 0;
	ogc_ctrl #(.OFF_DELAY_CYC(OFF), .RATE_LO_CYC(PLO), .RATE_HI_CYC(PHI)) u_ogc_ctrl (.*);
	ogc_host_model u_host (.*);
	initial forever #50 core_clk = ~core_clk;
	////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	////////////////////////////////////////////////
	task automatic t_regs();
		chk(ctrl2_rd_data | ctrl3_rd_data, 16'h0000, "reset value");
		u_host.wr(2'h2, 16'hFFFF, 1'b1);
		chk(ctrl2_rd_data, 16'hFCFC, "word 2 mask");
		u_host.wr(2'h3, 16'hFFFF, 1'b0);
		chk(ctrl3_rd_data, 16'hFFE0, "word 3 mask");
		u_host.wr(2'h0, 16'h0000, 1'b0);
		chk(ctrl2_rd_data, 16'hFCFC, "index 0 ignored");
		global_enable = 1'b0;
		u_host.wr(2'h2, 16'h8000, 1'b0);
		chk(ctrl2_rd_data | ctrl3_rd_data, 16'h0000, "standby clear");
		global_enable = 1'b1;
		$display("t_regs done");
	endtask
	task automatic t_bridge();
		upper_on_req = 6'h3F;
		lower_on_req = 6'h15;
		cyc(2);
		chk(16'(upper_switch_on), 16'h002A, "upper drive");
		chk(16'(lower_switch_on), 16'h0000, "lower drive");
		$display("t_bridge done");
	endtask
	task automatic t_gate();
		u_host.wr(2'h2, 16'h00FC, 1'b0);
		u_host.wr(2'h3, 16'h07C0, 1'b0);
		lower_on_req = 6'h00;
		single_on_req = 5'h1F;
		for (int i = 0; i < 2; i++) begin
			u_host.pulse(i[0], !i[0]);
			cyc(5);
			// outputs 5, 8, 10 follow input b
			chk(16'({single_switch_on, upper_switch_on}),
			    16'(i[0] ? 11'h56F : 11'h290), "gate");
		end
		$display("t_gate done");
	endtask
	task automatic t_retry();
		int n;
		for (int r = 0; r < 2; r++) begin
			u_host.wr(2'h3, r[0] ? 16'h8020 : 16'h8000, 1'b0);
			u_host.wr(2'h2, 16'h0000, 1'b0);
			upper_on_req = 6'h01;
			single_on_req = 5'h01;
			cyc(2);
			overcurrent_det = 17'h01001;
			cyc(1);
			overcurrent_det = 17'h00000;
			chk(16'({single_switch_on[0], upper_switch_on[0]}), 16'h0000, "trip off");
			chk(overcurrent_flag_word0, 16'h8000, "flag word 0");
			chk(overcurrent_flag_word1, 16'h8000, "flag word 1");
			n = 0;
			while (single_switch_on[0] !== 1'b1 && n < 100) begin
				cyc(1);
				n++;
			end
			chk(16'(n >= OFF && n <= OFF + (r ? PHI : PLO) + 3), 16'h0001, "retry");
			if (n == 100)
				wrap_up();
			// output 1 has no retry bit, so it stays latched off
			chk(16'(upper_switch_on[0]), 16'h0000, "latched off");
			// dropping the request releases the latch for the next pass
			upper_on_req = 6'h00;
			status_clr = 2'h3;
			cyc(1);
			status_clr = 2'h0;
			chk(overcurrent_flag_word0 | overcurrent_flag_word1, 16'h0000, "flag clear");
		end
		$display("t_retry done");
	endtask
	////////////////////////////////////////////////
	initial begin
		cyc(5);
		nrst = 1'b1;
		global_enable = 1'b1;
		cyc(1);
		t_regs();
		t_bridge();
		t_gate();
		t_retry();
		wrap_up();
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		err_count++;
		$display("Error %0t run limit", $time);
		wrap_up();
	end
endmodule
bind ogc_ctrl ogc_ctrl_props #(.OFF_DELAY_CYC(OFF_DELAY_CYC), .RATE_LO_CYC(RATE_LO_CYC),
	.RATE_HI_CYC(RATE_HI_CYC)) u_ogc_ctrl_props (.*);

// >>> logic/ogc_ctrl.sv
// retry and pulse-gate control words with per-switch over-current handling
`timescale 1ns/10ps
module ogc_ctrl #(
	parameter int OFF_DELAY_CYC = ogc_pkg::OFF_DELAY_CYC,
	parameter int RATE_LO_CYC   = ogc_pkg::RATE_LO_CYC,
	parameter int RATE_HI_CYC   = ogc_pkg::RATE_HI_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// register access from the serial frame decoder
	input  wire logic        reg_wr_en,
	input  wire logic [1:0]  reg_wr_idx,
	input  wire logic [15:0] reg_wr_data,
	output logic [15:0]      ctrl2_rd_data,
	output logic [15:0]      ctrl3_rd_data,
	// mode
	input  wire logic        global_enable,
	// on requests from the basic output words
	input  wire logic [5:0]  upper_on_req,
	input  wire logic [5:0]  lower_on_req,
	input  wire logic [4:0]  single_on_req,
	// pulse inputs, asynchronous to core_clk
	input  wire logic        pulse_gate_input_a,
	input  wire logic        pulse_gate_input_b,
	// over-current detectors, one per switch
	input  wire logic [16:0] overcurrent_det,
	// status word clear strobes
	input  wire logic [1:0]  status_clr,
	// status words
	output logic [15:0]      overcurrent_flag_word0,
	output logic [15:0]      overcurrent_flag_word1,
	// switch drives
	output logic [5:0]       upper_switch_on,
	output logic [5:0]       lower_switch_on,
	output logic [4:0]       single_switch_on
);

	localparam int NSW = ogc_pkg::NUM_SW;
	localparam int CW  = ogc_pkg::CNT_W;

	//////////////////////////////////////////////////////////////////////
	// helpers

	// switch index to output index: bridges use two switches each
	function automatic int sw_out(input int sw);
		sw_out = (sw < 12) ? (sw / 2) : (sw - 6);
	endfunction

	// decode the two control words into the carrier
	function automatic ogc_pkg::ogc_cfg_t cfg_of(input logic [15:0] w2,
	                                              input logic [15:0] w3);
		ogc_pkg::ogc_cfg_t c;
		c = '0;
		for (int i = 0; i < ogc_pkg::NUM_HB; i++) begin
			c.retry_en[i] = w2[15 - i];
			c.gate_en[i]  = w2[7 - i];
		end
		for (int i = 0; i < ogc_pkg::NUM_SINGLE; i++) begin
			c.retry_en[6 + i] = w3[15 - i];
			c.gate_en[6 + i]  = w3[10 - i];
		end
		c.rate_sel = w3[ogc_pkg::C3_RATE_BIT];
		return c;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// control words

	logic [15:0]       ctrl2_q;
	logic [15:0]       ctrl2_d;
	logic [15:0]       ctrl3_q;
	logic [15:0]       ctrl3_d;
	ogc_pkg::ogc_cfg_t cfg;

	always_comb begin
		ctrl2_d = ctrl2_q;
		ctrl3_d = ctrl3_q;
		if (!global_enable) begin
			ctrl2_d = ogc_pkg::CTRL_RESET;
			ctrl3_d = ogc_pkg::CTRL_RESET;
		end else if (reg_wr_en && reg_wr_idx == ogc_pkg::REG_IDX_CTRL2) begin
			// host keeps bits 9,8 at zero; hold them zero regardless
			ctrl2_d = reg_wr_data & ogc_pkg::C2_WMASK;
		end else if (reg_wr_en && reg_wr_idx == ogc_pkg::REG_IDX_CTRL3) begin
			ctrl3_d = reg_wr_data & ogc_pkg::C3_WMASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl2_q <= ogc_pkg::CTRL_RESET;
			ctrl3_q <= ogc_pkg::CTRL_RESET;
		end else begin
			ctrl2_q <= ctrl2_d;
			ctrl3_q <= ctrl3_d;
		end
	end

	assign cfg           = cfg_of(ctrl2_q, ctrl3_q);
	assign ctrl2_rd_data = ctrl2_q;
	assign ctrl3_rd_data = ctrl3_q;

	//////////////////////////////////////////////////////////////////////
	// pulse input synchronisers

	logic [1:0] pin_meta_q;
	logic [1:0] pin_sync_q;
	logic [1:0] pin_meta_d;
	logic [1:0] pin_sync_d;

	always_comb begin
		pin_meta_d = {pulse_gate_input_b, pulse_gate_input_a};
		pin_sync_d = pin_meta_q;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_meta_q <= 2'h0;
			pin_sync_q <= 2'h0;
		end else begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// retry rate tick

	logic tick;

	ogc_rate_tick #(
		.LO_CYC   (RATE_LO_CYC),
		.HI_CYC   (RATE_HI_CYC)
	) u_tick (
		.core_clk (core_clk),
		.nrst     (nrst),
		.run      (global_enable),
		.rate_sel (cfg.rate_sel),
		.tick     (tick)
	);

	//////////////////////////////////////////////////////////////////////
	// per switch request and gating

	logic [NSW-1:0]  req;
	logic [NSW-1:0]  gated_req;
	logic [10:0]     pulse_level;

	always_comb begin
		for (int o = 0; o < ogc_pkg::NUM_OUT; o++) begin
			// input b for outputs 5, 8, 10, input a otherwise
			pulse_level[o] = ogc_pkg::GATE_B_MASK[o] ? pin_sync_q[1] : pin_sync_q[0];
		end
		for (int h = 0; h < ogc_pkg::NUM_HB; h++) begin
			req[2 * h]     = upper_on_req[h];
			req[2 * h + 1] = lower_on_req[h];
		end
		for (int s = 0; s < ogc_pkg::NUM_SINGLE; s++) begin
			req[12 + s] = single_on_req[s];
		end
		for (int i = 0; i < NSW; i++) begin
			// gated switch conducts only while its pulse input is high
			gated_req[i] = req[i] & (~cfg.gate_en[sw_out(i)] | pulse_level[sw_out(i)]);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// over-current retry machines

	ogc_pkg::ogc_sw_state_t state_q [NSW];
	ogc_pkg::ogc_sw_state_t state_d [NSW];
	logic [CW-1:0]          cnt_q [NSW];
	logic [CW-1:0]          cnt_d [NSW];
	logic [NSW-1:0]         armed_q;
	logic [NSW-1:0]         armed_d;
	logic [10:0]            snap_q;
	logic [10:0]            snap_d;
	logic [NSW-1:0]         trip;
	logic [NSW-1:0]         drive_q;

	// enables sampled at each tick; a trip after a clear still sees the old
	// sample, which gives the single phase dependent retry
	always_comb begin
		snap_d = snap_q;
		if (!global_enable) begin
			snap_d = 11'h000;
		end else if (tick) begin
			snap_d = cfg.retry_en;
		end
	end

	always_comb begin
		for (int i = 0; i < NSW; i++) begin
			state_d[i] = state_q[i];
			cnt_d[i]   = cnt_q[i];
			armed_d[i] = armed_q[i];
			trip[i]    = 1'b0;
			if (!global_enable) begin
				state_d[i] = ogc_pkg::SW_RUN;
				cnt_d[i]   = '0;
				armed_d[i] = 1'b0;
			end else begin
				case (state_q[i])
					ogc_pkg::SW_RUN: begin
						if (overcurrent_det[i] && drive_q[i]) begin
							trip[i]    = 1'b1;
							state_d[i] = ogc_pkg::SW_HOLD_OFF;
							cnt_d[i]   = CW'(OFF_DELAY_CYC - 1);
							// stale sample may allow one retry
							armed_d[i] = cfg.retry_en[sw_out(i)] | snap_q[sw_out(i)];
						end
					end
					ogc_pkg::SW_HOLD_OFF: begin
						if (cnt_q[i] == '0) begin
							state_d[i] = ogc_pkg::SW_WAIT_TICK;
						end else begin
							cnt_d[i] = cnt_q[i] - 1'b1;
						end
					end
					ogc_pkg::SW_WAIT_TICK: begin
						if (tick) begin
							// re-activate on the rate grid, forming the pulsed current
							state_d[i] = armed_q[i] ? ogc_pkg::SW_RUN : ogc_pkg::SW_LATCHED;
						end
					end
					ogc_pkg::SW_LATCHED: begin
						// stays off until the host drops the on request
						if (!req[i]) begin
							state_d[i] = ogc_pkg::SW_RUN;
						end
					end
					default: begin
						state_d[i] = ogc_pkg::SW_RUN;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < NSW; i++) begin
				state_q[i] <= ogc_pkg::SW_RUN;
				cnt_q[i] <= '0;
			end
			armed_q <= '0;
			snap_q  <= 11'h000;
		end else begin
			for (int i = 0; i < NSW; i++) begin
				state_q[i] <= state_d[i];
				cnt_q[i] <= cnt_d[i];
			end
			armed_q <= armed_d;
			snap_q  <= snap_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// switch drive

	logic [NSW-1:0] drive_d;

	always_comb begin
		for (int i = 0; i < NSW; i++) begin
			// tripped switch is off at once, same cycle as the flag
			drive_d[i] = global_enable & gated_req[i] & ~trip[i]
			             & (state_d[i] == ogc_pkg::SW_RUN);
		end
		for (int h = 0; h < ogc_pkg::NUM_HB; h++) begin
			// both requested: neither conducts, avoids a supply short
			if (req[2 * h] && req[2 * h + 1]) begin
				drive_d[2 * h]     = 1'b0;
				drive_d[2 * h + 1] = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign upper_switch_on = {drive_q[10], drive_q[8], drive_q[6],
	                          drive_q[4], drive_q[2], drive_q[0]};
	assign lower_switch_on = {drive_q[11], drive_q[9], drive_q[7],
	                          drive_q[5], drive_q[3], drive_q[1]};
	assign single_switch_on = drive_q[16:12];

	//////////////////////////////////////////////////////////////////////
	// over-current status words

	logic [11:0] flag0_q;
	logic [11:0] flag0_d;
	logic [4:0]  flag1_q;
	logic [4:0]  flag1_d;

	always_comb begin
		flag0_d = flag0_q;
		flag1_d = flag1_q;
		if (status_clr[0]) begin
			flag0_d = 12'h000;
		end
		if (status_clr[1]) begin
			flag1_d = 5'h00;
		end
		// set after clear so a coincident event is kept
		for (int i = 0; i < 12; i++) begin
			// bridge i/2, upper then lower, from bit 15 down
			if (trip[i]) begin
				flag0_d[11 - i] = 1'b1;
			end
		end
		for (int s = 0; s < ogc_pkg::NUM_SINGLE; s++) begin
			if (trip[12 + s]) begin
				flag1_d[4 - s] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flag0_q <= 12'h000;
			flag1_q <= 5'h00;
		end else begin
			flag0_q <= flag0_d;
			flag1_q <= flag1_d;
		end
	end

	assign overcurrent_flag_word0 = {flag0_q, 4'h0};
	assign overcurrent_flag_word1 = {flag1_q, 11'h000};

endmodule

// >>> logic/ogc_pkg.sv
// constants, field layout and carrier types for the retry and pulse-gate control block
package ogc_pkg;

	localparam int NUM_OUT = 11;
	localparam int NUM_HB  = 6;
	localparam int NUM_SINGLE = 5;
	localparam int NUM_SW  = 17;
	localparam int CNT_W   = 16;

	// register indices on the serial word map
	localparam logic [1:0] REG_IDX_CTRL2 = 2'h2;
	localparam logic [1:0] REG_IDX_CTRL3 = 2'h3;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;

	// field positions
	localparam int C2_RETRY_LO = 10;
	localparam int C2_GATE_LO  = 2;
	localparam int C3_RETRY_LO = 11;
	localparam int C3_GATE_LO  = 6;
	localparam int C3_RATE_BIT = 5;
	localparam int S0_FLAG_LO  = 4;
	localparam int S1_FLAG_LO  = 11;

	// writable bits; bits 9,8 and 1,0 of word 2 are held at zero
	localparam logic [15:0] C2_WMASK = 16'hFCFC;
	localparam logic [15:0] C3_WMASK = 16'hFFE0;

	// outputs gated by input b: 5, 8 and 10 (zero based bits 4, 7, 9)
	localparam logic [10:0] GATE_B_MASK = 11'h290;

	// timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int RATE_LO_DHZ   = 17_000;
	localparam int RATE_HI_HZ    = 3_000;
	localparam int OFF_DELAY_US  = 100;
	localparam int RATE_LO_CYC   = (CLK_HZ * 10) / RATE_LO_DHZ;
	localparam int RATE_HI_CYC   = CLK_HZ / RATE_HI_HZ;
	localparam int OFF_DELAY_CYC = (OFF_DELAY_US * CLK_HZ + 999_999) / 1_000_000;

	typedef struct packed {
		logic [10:0] retry_en;
		logic [10:0] gate_en;
		logic        rate_sel;
	} ogc_cfg_t;

	typedef enum logic [1:0] {
		SW_RUN,
		SW_HOLD_OFF,
		SW_WAIT_TICK,
		SW_LATCHED
	} ogc_sw_state_t;

endpackage

// >>> logic/ogc_rate_tick.sv
// free running retry-rate tick generator
`timescale 1ns/10ps
module ogc_rate_tick #(
	parameter int LO_CYC = ogc_pkg::RATE_LO_CYC,
	parameter int HI_CYC = ogc_pkg::RATE_HI_CYC
) (
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	// control
	input  wire logic                       run,
	input  wire logic                       rate_sel,
	// tick
	output logic                            tick
);

	logic [ogc_pkg::CNT_W-1:0] cnt_q;
	logic [ogc_pkg::CNT_W-1:0] cnt_d;
	logic                      tick_d;

	always_comb begin
		tick_d = 1'b0;
		cnt_d  = cnt_q;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q == '0) begin
			tick_d = 1'b1;
			// reload picks the rate at each period boundary
			cnt_d = rate_sel ? ogc_pkg::CNT_W'(HI_CYC - 1) : ogc_pkg::CNT_W'(LO_CYC - 1);
		end else begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= tick_d;
		end
	end

endmodule
